// ---- common/flash_prot_pkg.sv ----
/*
 * Constants shared by the flash protection host controller: software register
 * map, field positions, reset values, bus-cycle timing and protection units.
 * Assumes a 100 MHz ref_clk and a device with a 20-bit word address.
 */
package flash_prot_pkg;
    // Clock and flash bus-cycle timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int WE_LOW_NS = 50;
    localparam int WE_LOW_CYC = (WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_NS = 100;
    localparam int RD_ACCESS_CYC = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_LOW_NS = 500;
    localparam int RST_LOW_CYC = (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Flash geometry
    localparam int FL_ADDR_W = 20;
    localparam int FL_DATA_W = 16;
    localparam int NUM_UNITS = 17;
    localparam int UNIT_W = 5;

    // Upper address byte (A19-A12) that selects each protection unit
    localparam logic [7:0] UNIT_CODE [NUM_UNITS] = '{
        8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
        8'h08, 8'h20, 8'h40, 8'h60, 8'h80, 8'ha0, 8'hc0, 8'he0, 8'hf8};

    // Software register offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_KEEP = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0c;
    localparam logic [7:0] REG_MAP = 8'h10;

    // Field positions and reset values
    localparam int CTRL_WP_BIT = 0;
    localparam int CTRL_TEMP_BIT = 1;
    localparam logic [1:0] CTRL_RST_VAL = 2'h1;
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_UNIT_LSB = 8;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_ERR_BIT = 1;
    localparam int ST_SEC_BIT = 2;
    localparam int ST_VER_BIT = 3;

    typedef enum logic [2:0] {
        OP_NONE, OP_PROTECT, OP_UNPROT_ALL, OP_VERIFY, OP_ENTER_SEC, OP_EXIT_SEC, OP_HW_RESET
    } op_t;
endpackage : flash_prot_pkg

// ---- design/flash_bus_cycle.sv ----
/*
 * One processor-style flash bus cycle (write or read): setup, strobe, hold.
 * Assumes the caller raises start only while busy is low; dq_in is synchronous.
 */
`timescale 1ns/1ps
module flash_bus_cycle #(
    parameter int ADDR_W = 20,
    parameter int DATA_W = 16
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Request and answer
    input wire logic start,
    input wire logic is_write,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    output logic busy,
    output logic done,
    output logic [DATA_W-1:0] rdata,
    // Flash pins
    output logic [ADDR_W-1:0] fl_addr,
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic dq_oe_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n
);
    // Command codes ride on the low data byte, so narrower buses cannot work
    if (ADDR_W < 1 || DATA_W < 8) begin : g_chk
        $error("flash_bus_cycle: width parameter out of range");
    end
    typedef enum logic [1:0] {B_IDLE, B_SETUP, B_ACT, B_HOLD} bstate_t;
    bstate_t st_r;
    logic wr_r;
    logic [7:0] cnt_r;

    // Address and data settle one cycle before the strobe, and stay one after
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= B_IDLE;
            wr_r <= 1'b0;
            cnt_r <= 8'h00;
            busy <= 1'b0;
            done <= 1'b0;
            rdata <= '0;
            fl_addr <= '0;
            dq_out <= '0;
            dq_oe_n <= 1'b1;
            ce_n <= 1'b1;
            oe_n <= 1'b1;
            we_n <= 1'b1;
        end else if (clk_en) begin
            done <= 1'b0;
            unique case (st_r)
                B_IDLE: begin
                    if (start) begin
                        fl_addr <= addr;
                        dq_out <= wdata;
                        wr_r <= is_write;
                        dq_oe_n <= !is_write;
                        ce_n <= 1'b0;
                        busy <= 1'b1;
                        st_r <= B_SETUP;
                    end
                end
                B_SETUP: begin
                    we_n <= !wr_r;
                    oe_n <= wr_r;
                    cnt_r <= wr_r ? 8'(flash_prot_pkg::WE_LOW_CYC - 1) : 8'(flash_prot_pkg::RD_ACCESS_CYC - 1);
                    st_r <= B_ACT;
                end
                B_ACT: begin
                    if (cnt_r == 8'h00) begin
                        we_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (!wr_r) begin
                            rdata <= dq_in;
                        end
                        done <= 1'b1;
                        st_r <= B_HOLD;
                    end else begin
                        cnt_r <= cnt_r - 8'h01;
                    end
                end
                B_HOLD: begin
                    ce_n <= 1'b1;
                    dq_oe_n <= 1'b1;
                    busy <= 1'b0;
                    st_r <= B_IDLE;
                end
            endcase
        end
    end
endmodule : flash_bus_cycle

// ---- design/flash_prot_host.sv ----
/*
 * Host controller that drives a parallel flash through its pins to protect,
 * unprotect and verify protection units, to hold temporary unprotect, and to
 * enter or leave the secured sector. Software uses a plain register port.
 * Assumes one 100 MHz clock and flash inputs synchronous to it.
 */
`timescale 1ns/1ps
// Summary of operation
// - Protect and unprotect only with elevated voltage, using normal bus cycles.
// - Before unprotecting, host protects every unit first.
// - Unprotect clears all units; host re-protects chosen units one by one.
// - Host always drives the write-protect pin to a defined level.
// - Host enters secured mode with three cycles and leaves with exit sequence.
module flash_prot_host #(
    parameter int PROT_WAIT_CYC = 1000,
    parameter int MAX_TRIES = 25,
    parameter logic [7:0] PROT_CODE = 8'h01,
    parameter logic [7:0] UNPROT_CODE = 8'h02,
    parameter logic [7:0] VERIFY_CODE = 8'h03,
    parameter logic [7:0] UNLOCK_A = 8'h04,
    parameter logic [7:0] UNLOCK_B = 8'h05,
    parameter logic [7:0] ENTER_CODE = 8'h06,
    parameter logic [7:0] EXIT_CODE = 8'h07,
    parameter logic [19:0] UNLOCK_ADDR_A = 20'h00001,
    parameter logic [19:0] UNLOCK_ADDR_B = 20'h00002
) (
    // Clock, reset, enable
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // Software register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Flash pins
    output logic [19:0] flash_addr,
    input wire logic [15:0] dq_in,
    output logic [15:0] dq_out,
    output logic dq_oe_n,
    output logic ce_n,
    output logic oe_n,
    output logic we_n,
    output logic reset_n,
    output logic elevated_id_voltage,
    output logic write_protect_accel_pin
);
    localparam int NU = flash_prot_pkg::NUM_UNITS;
    if (PROT_WAIT_CYC < 1 || PROT_WAIT_CYC > 65535 || MAX_TRIES < 1 || MAX_TRIES > 255) begin : g_chk
        $error("flash_prot_host: parameter out of range");
    end

    typedef enum logic [3:0] {S_IDLE, S_WR_PROT, S_PWAIT, S_WR_VER, S_RD_VER, S_SCAN, S_SEQ, S_RST} state_t;
    typedef enum logic [2:0] {PH_SINGLE, PH_ALL, PH_UNP, PH_KEEP, PH_VERIFY} phase_t;

    state_t st_r;
    phase_t ph_r;
    logic [1:0] ctrl_r;
    logic [NU-1:0] keep_r;
    logic [NU-1:0] map_r;
    logic [4:0] unit_r;
    logic [7:0] tries_r;
    logic [15:0] wait_r;
    logic [1:0] seq_r;
    logic exit_r;
    logic pend_r;
    logic err_r;
    logic sec_r;
    logic ver_r;
    logic vid_r;
    logic rst_n_r;
    logic wp_r;

    // Bus cycle engine and its request
    logic bus_busy;
    logic bus_done;
    logic [15:0] bus_rdata;
    wire in_bus_st = (st_r == S_WR_PROT) || (st_r == S_WR_VER) || (st_r == S_RD_VER) || (st_r == S_SEQ);
    wire bus_req = in_bus_st && !pend_r && !bus_busy;
    wire bus_is_wr = (st_r != S_RD_VER);
    wire [19:0] unit_addr = {flash_prot_pkg::UNIT_CODE[unit_r], 12'h000};
    wire [7:0] seq_code = (seq_r == 2'd0) ? UNLOCK_A : (seq_r == 2'd1) ? UNLOCK_B : (exit_r ? EXIT_CODE : ENTER_CODE);
    wire [19:0] seq_addr = (seq_r == 2'd1) ? UNLOCK_ADDR_B : UNLOCK_ADDR_A;
    wire [7:0] op_code = (st_r == S_WR_PROT) ? ((ph_r == PH_UNP) ? UNPROT_CODE : PROT_CODE) : VERIFY_CODE;
    wire [7:0] bus_code = (st_r == S_SEQ) ? seq_code : op_code;
    wire [19:0] bus_addr = (st_r == S_SEQ) ? seq_addr : unit_addr;

    flash_bus_cycle #(.ADDR_W(20), .DATA_W(16)) u_bus (
        .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .start(bus_req), .is_write(bus_is_wr), .addr(bus_addr), .wdata({8'h00, bus_code}),
        .busy(bus_busy), .done(bus_done), .rdata(bus_rdata),
        .fl_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n));

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == flash_prot_pkg::REG_CTRL);
    wire wr_cmd = reg_wr && (reg_addr == flash_prot_pkg::REG_CMD) && (st_r == S_IDLE);
    wire wr_keep = reg_wr && (reg_addr == flash_prot_pkg::REG_KEEP);
    wire [2:0] cmd_op = reg_wdata[flash_prot_pkg::CMD_OP_LSB +: 3];
    wire [4:0] cmd_unit = reg_wdata[flash_prot_pkg::CMD_UNIT_LSB +: 5];
    wire unit_bad = (cmd_unit >= 5'(NU));
    wire [3:0] status_w = {ver_r, sec_r, err_r, st_r != S_IDLE};
    wire [31:0] rd_mux =
        (reg_addr == flash_prot_pkg::REG_CTRL) ? {30'h0, ctrl_r} :
        (reg_addr == flash_prot_pkg::REG_KEEP) ? {15'h0, keep_r} :
        (reg_addr == flash_prot_pkg::REG_STATUS) ? {28'h0, status_w} :
        (reg_addr == flash_prot_pkg::REG_MAP) ? {15'h0, map_r} : 32'h0;
    // Verify result: protect expects 1, unprotect expects 0
    wire ver_bit = bus_rdata[0];
    wire ver_ok = (ph_r == PH_UNP) ? !ver_bit : ver_bit;
    wire last_unit = (unit_r == 5'(NU - 1));

    // Register side and the pin levels software owns
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= flash_prot_pkg::CTRL_RST_VAL;
            keep_r <= '0;
            reg_rdata <= 32'h0;
            wp_r <= 1'b1;
            vid_r <= 1'b0;
        end else if (clk_en) begin
            if (wr_ctrl) ctrl_r <= reg_wdata[1:0];
            if (wr_keep) keep_r <= reg_wdata[NU-1:0];
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
            wp_r <= ctrl_r[flash_prot_pkg::CTRL_WP_BIT];
            // Elevated voltage during protect work or while temporary unprotect is asked for
            vid_r <= ((st_r != S_IDLE) && (ph_r != PH_VERIFY) && (st_r != S_SEQ) && (st_r != S_RST))
                     || ctrl_r[flash_prot_pkg::CTRL_TEMP_BIT];
        end
    end

    // Sequencer; the pending flag keeps one bus cycle per state visit, except S_SEQ, which runs three in one visit
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_r <= S_IDLE;
            ph_r <= PH_SINGLE;
            unit_r <= 5'h0;
            tries_r <= 8'h0;
            wait_r <= 16'h0;
            seq_r <= 2'd0;
            exit_r <= 1'b0;
            pend_r <= 1'b0;
            err_r <= 1'b0;
            sec_r <= 1'b0;
            ver_r <= 1'b0;
            map_r <= '0;
            rst_n_r <= 1'b1;
        end else if (clk_en) begin
            if (bus_req) pend_r <= 1'b1;
            else if (bus_done) pend_r <= 1'b0;
            unique case (st_r)
                S_IDLE: begin
                    tries_r <= 8'h0;
                    seq_r <= 2'd0;
                    if (wr_cmd) begin
                        unit_r <= cmd_unit;
                        err_r <= 1'b0;
                        unique case (flash_prot_pkg::op_t'(cmd_op))
                            flash_prot_pkg::OP_PROTECT: begin
                                if (unit_bad) err_r <= 1'b1;
                                else begin ph_r <= PH_SINGLE; st_r <= S_WR_PROT; end
                            end
                            flash_prot_pkg::OP_UNPROT_ALL: begin
                                ph_r <= PH_ALL;
                                unit_r <= 5'h0;
                                st_r <= S_WR_PROT;
                            end
                            flash_prot_pkg::OP_VERIFY: begin
                                if (unit_bad) err_r <= 1'b1;
                                else begin ph_r <= PH_VERIFY; st_r <= S_WR_VER; end
                            end
                            flash_prot_pkg::OP_ENTER_SEC: begin exit_r <= 1'b0; st_r <= S_SEQ; end
                            flash_prot_pkg::OP_EXIT_SEC: begin exit_r <= 1'b1; st_r <= S_SEQ; end
                            flash_prot_pkg::OP_HW_RESET: begin
                                wait_r <= 16'(flash_prot_pkg::RST_LOW_CYC - 1);
                                rst_n_r <= 1'b0;
                                st_r <= S_RST;
                            end
                            default: err_r <= 1'b1;
                        endcase
                    end
                end
                S_WR_PROT: if (bus_done) begin
                    wait_r <= 16'(PROT_WAIT_CYC - 1);
                    st_r <= S_PWAIT;
                end
                S_PWAIT: begin
                    if (wait_r == 16'h0) st_r <= S_WR_VER;
                    else wait_r <= wait_r - 16'h1;
                end
                S_WR_VER: if (bus_done) st_r <= S_RD_VER;
                S_RD_VER: if (bus_done) begin
                    if (ph_r == PH_VERIFY) begin
                        map_r[unit_r] <= ver_bit;
                        ver_r <= ver_bit;
                        st_r <= S_IDLE;
                    end else if (ver_ok) begin
                        tries_r <= 8'h0;
                        ver_r <= ver_bit;
                        unique case (ph_r)
                            PH_SINGLE: begin map_r[unit_r] <= 1'b1; st_r <= S_IDLE; end
                            PH_ALL: begin
                                map_r[unit_r] <= 1'b1;
                                if (last_unit) begin ph_r <= PH_UNP; unit_r <= 5'h0; end
                                else unit_r <= unit_r + 5'h1;
                                st_r <= S_WR_PROT;
                            end
                            PH_UNP: begin map_r <= '0; ph_r <= PH_KEEP; st_r <= S_SCAN; end
                            default: begin map_r[unit_r] <= 1'b1; unit_r <= unit_r + 5'h1; st_r <= S_SCAN; end
                        endcase
                    end else if (tries_r == 8'(MAX_TRIES - 1)) begin
                        err_r <= 1'b1;
                        st_r <= S_IDLE;
                    end else begin
                        tries_r <= tries_r + 8'h1;
                        st_r <= S_WR_PROT;
                    end
                end
                // Re-protect only the units software marked to keep
                S_SCAN: begin
                    if (unit_r == 5'(NU)) st_r <= S_IDLE;
                    else if (keep_r[unit_r]) st_r <= S_WR_PROT;
                    else unit_r <= unit_r + 5'h1;
                end
                S_SEQ: if (bus_done) begin
                    if (seq_r == 2'd2) begin
                        sec_r <= !exit_r;
                        st_r <= S_IDLE;
                    end else seq_r <= seq_r + 2'd1;
                end
                S_RST: begin
                    if (wait_r == 16'h0) begin
                        rst_n_r <= 1'b1;
                        sec_r <= 1'b0;
                        st_r <= S_IDLE;
                    end else wait_r <= wait_r - 16'h1;
                end
            endcase
        end
    end

    assign reset_n = rst_n_r;
    assign elevated_id_voltage = vid_r;
    assign write_protect_accel_pin = wp_r;

    // Helper counters watched by the checks below
    logic [7:0] we_low_cnt;
    logic [1:0] seq_wr_cnt;
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            we_low_cnt <= 8'h0;
            seq_wr_cnt <= 2'd0;
        end else if (clk_en) begin
            we_low_cnt <= we_n ? 8'h0 : we_low_cnt + 8'h1;
            if (st_r != S_SEQ) seq_wr_cnt <= 2'd0;
            else if (bus_done) seq_wr_cnt <= seq_wr_cnt + 2'd1;
        end
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (sys_rst || !clk_en);

    chk_vid_prot_write: assert property ((st_r == S_WR_PROT) && !we_n |-> elevated_id_voltage)
        else $error("protect write without elevated voltage");
    chk_unprot_after_all: assert property ((st_r == S_WR_PROT) && (ph_r == PH_UNP) |-> map_r == '1)
        else $error("unprotect issued before all units protected");
    chk_map_clear: assert property ((st_r == S_RD_VER) && (ph_r == PH_UNP) && bus_done && !bus_rdata[0]
        |=> (map_r == '0) && (st_r == S_SCAN))
        else $error("unprotect did not clear the map");
    chk_wp_follows: assert property (wr_ctrl |-> ##2 write_protect_accel_pin == $past(reg_wdata[0], 2))
        else $error("write-protect pin not following control");
    chk_enter_three: assert property ($rose(sec_r) |-> $past(seq_wr_cnt) == 2'd2)
        else $error("secured mode entered without three writes");
    chk_rst_clears_sec: assert property ($rose(reset_n) |-> !sec_r)
        else $error("secured mode survived reset pulse");
    chk_temp_vid: assert property ((st_r == S_IDLE) && ctrl_r[1] |=> elevated_id_voltage)
        else $error("temporary unprotect voltage missing");
    chk_we_width: assert property ($rose(we_n) |-> we_low_cnt == 8'(flash_prot_pkg::WE_LOW_CYC))
        else $error("write strobe width wrong");

    cov_unprot_all: cover property ((st_r == S_SCAN) && (unit_r == 5'(NU)));
    cov_sec_enter: cover property ($rose(sec_r));
    cov_retry: cover property ((st_r == S_RD_VER) && bus_done && !ver_ok && (ph_r != PH_VERIFY));
endmodule : flash_prot_host

// ---- tb/flash_dev_model.sv ----
/* Behavioural parallel flash seen from its pins: protect state per unit, verify reads, secured entry.
   Assumes the host's pins change on ref_clk and that dq_in is sampled on ref_clk. */
`timescale 1ns/1ps
module flash_dev_model #(
    parameter logic [7:0] PROT_CODE = 8'h01,
    parameter logic [7:0] UNPROT_CODE = 8'h02,
    parameter logic [7:0] VERIFY_CODE = 8'h03,
    parameter logic [7:0] UNLOCK_A = 8'h04,
    parameter logic [7:0] UNLOCK_B = 8'h05,
    parameter logic [7:0] ENTER_CODE = 8'h06,
    parameter logic [7:0] EXIT_CODE = 8'h07,
    parameter logic FACTORY_LOCKED = 1'h0
) (
    // Clock
    input wire logic ref_clk,
    // Flash pins
    input wire logic [19:0] flash_addr,
    output logic [15:0] dq_in,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe_n,
    input wire logic ce_n,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic reset_n,
    input wire logic elevated_id_voltage,
    input wire logic write_protect_accel_pin
);
    logic [16:0] prot_r = 17'h0; // Shipped unprotected
    logic sec_r = 1'h0;
    logic sec_lock_r = FACTORY_LOCKED; // Factory parts arrive locked
    logic ver_r = 1'h0;
    logic [1:0] seq_r = 2'h0;
    logic we_q = 1'h1;
    logic rule_break = 1'h0;
    logic [15:0] last_r = 16'h0;
    logic [16:0] blocked;
    logic [4:0] unit;
    logic [7:0] code;
    // Upper address byte to protection unit
    function automatic logic [4:0] unit_of(input logic [7:0] a);
        if (a < 8'h08) return a[4:0];
        if (a < 8'h20) return 5'h08;
        if (a >= 8'hf8) return 5'h10;
        if (a >= 8'he0) return 5'h0f;
        return 5'h08 + {2'h0, a[7:5]};
    endfunction : unit_of
    assign unit = unit_of(flash_addr[19:12]);
    assign code = dq_out[7:0];
    // Units refusing program and erase
    assign blocked = (elevated_id_voltage ? 17'h0 : prot_r) | (write_protect_accel_pin ? 17'h0 : 17'h3);
    // A released bus toggles so stale data never looks valid; secured reads give the serial words
    assign dq_in = (!ce_n && !oe_n) ? (ver_r ? {15'h0, sec_r ? sec_lock_r : prot_r[unit]} :
        sec_r ? {13'h0, flash_addr[2:0]} : {15'h0, FACTORY_LOCKED}) : ~last_r;
    // Commands are taken on the rising edge of the write strobe
    always @(posedge ref_clk) begin
        we_q <= we_n;
        last_r <= dq_in;
        if (!reset_n) begin
            sec_r <= 1'h0;
            ver_r <= 1'h0;
            seq_r <= 2'h0;
        end else if (!we_q && we_n && !ce_n && !dq_oe_n) begin
            ver_r <= (code == VERIFY_CODE);
            seq_r <= (code == UNLOCK_A) ? 2'h1 : (seq_r == 2'h1 && code == UNLOCK_B) ? 2'h2 : 2'h0;
            if (seq_r == 2'h2 && code == ENTER_CODE) sec_r <= 1'h1;
            if (seq_r == 2'h2 && code == EXIT_CODE) sec_r <= 1'h0;
            if (code == PROT_CODE && elevated_id_voltage && !sec_r) prot_r[unit] <= 1'h1;
            // Locking the secured sector needs no high voltage and is never undone
            if (code == PROT_CODE && sec_r) sec_lock_r <= 1'h1;
            if (code == UNPROT_CODE && elevated_id_voltage) begin
                rule_break <= rule_break | (prot_r != 17'h1ffff);
                prot_r <= 17'h0;
            end
        end
    end
endmodule : flash_dev_model

// ---- tb/testbench.sv ----
/* Self-checking bench for the protection host with a flash model on its pins.
   Assumes the design's default command codes and a 100 MHz clock. */
`timescale 1ns/1ps
module testbench;
    typedef struct packed {logic [2:0] op; logic [4:0] unit; logic [3:0] st;} row_t;
    logic ref_clk = 1'h0;
    logic sys_rst = 1'h1;
    logic [7:0] reg_addr = 8'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'h0;
    logic reg_rd = 1'h0;
    logic [31:0] reg_rdata;
    logic [19:0] flash_addr;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    logic dq_oe_n, ce_n, oe_n, we_n, reset_n, vid, wp;
    int n_fail = 0;
    int checks_done = 0;
    logic [31:0] rv;
    logic [16:0] exp_map = 17'h0;
    row_t rows [15];
    always #5 ref_clk = ~ref_clk;
    flash_prot_host #(.PROT_WAIT_CYC(4), .MAX_TRIES(2)) dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'h1),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n),
        .we_n(we_n), .reset_n(reset_n), .elevated_id_voltage(vid), .write_protect_accel_pin(wp));
    flash_dev_model dev (.ref_clk(ref_clk), .flash_addr(flash_addr), .dq_in(dq_in), .dq_out(dq_out),
        .dq_oe_n(dq_oe_n), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
        .elevated_id_voltage(vid), .write_protect_accel_pin(wp));
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            n_fail++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    // One-cycle register strobes, changed just after the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge ref_clk);
        reg_wr <= 1'h0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge ref_clk);
        reg_rd <= 1'h0;
        #1 rv = reg_rdata;
    endtask : rd
    // Poll busy with a bound so a hung sequencer ends the run
    task automatic wait_idle;
        for (int i = 0; i < 3000; i++) begin
            rd(flash_prot_pkg::REG_STATUS);
            if (rv[flash_prot_pkg::ST_BUSY_BIT] === 1'h0) return;
        end
        check(rv, 32'h0);
        tally_and_finish();
    endtask : wait_idle
    // Drive pin levels from CTRL, then check pins and blocked units
    task automatic ctl(input logic [1:0] v, input logic [16:0] eb);
        wr(flash_prot_pkg::REG_CTRL, {30'h0, v});
        repeat (3) @(posedge ref_clk);
        check({30'h0, vid, wp}, {30'h0, v});
        check({15'h0, dev.blocked}, {15'h0, eb});
    endtask : ctl
    initial begin
        rows = '{'{3'h1, 5'h00, 4'h0}, '{3'h1, 5'h01, 4'h0}, '{3'h1, 5'h07, 4'h0}, '{3'h1, 5'h08, 4'h0},
            '{3'h1, 5'h0e, 4'h0}, '{3'h1, 5'h10, 4'h0}, '{3'h3, 5'h10, 4'h8}, '{3'h3, 5'h02, 4'h0},
            '{3'h4, 5'h00, 4'h4}, '{3'h6, 5'h00, 4'h0}, '{3'h4, 5'h00, 4'h4}, '{3'h5, 5'h00, 4'h0},
            '{3'h0, 5'h00, 4'h2}, '{3'h7, 5'h00, 4'h2}, '{3'h1, 5'h11, 4'h2}};
        repeat (12) @(posedge ref_clk);
        sys_rst <= 1'h0;
        check({25'h0, ce_n, oe_n, we_n, dq_oe_n, reset_n, vid, wp}, 32'h7d);
        rd(flash_prot_pkg::REG_CTRL);
        check(rv, {30'h0, flash_prot_pkg::CTRL_RST_VAL});
        wr(8'h14, 32'hffff);
        rd(8'h14);
        check(rv, 32'h0);
        rd(flash_prot_pkg::REG_MAP);
        check(rv, 32'h0);
        // Command table: protect, verify, secured entry, hw reset, refusals
        foreach (rows[k]) begin
            wr(flash_prot_pkg::REG_CMD, {19'h0, rows[k].unit, 5'h0, rows[k].op});
            wait_idle();
            check({28'h0, rv[3:0] & (rows[k].op == 3'h3 ? 4'hf : 4'h7)}, {28'h0, rows[k].st});
            if (rows[k].op == 3'h1 && rows[k].unit < 5'h11) exp_map[rows[k].unit] = 1'h1;
            check({15'h0, dev.prot_r}, {15'h0, exp_map});
            check({31'h0, dev.sec_r}, {31'h0, rows[k].st[2]});
        end
        rd(flash_prot_pkg::REG_MAP);
        check(rv, {15'h0, exp_map});
        // A command while busy is dropped
        wr(flash_prot_pkg::REG_CMD, 32'h0301);
        wr(flash_prot_pkg::REG_CMD, 32'h0004);
        wait_idle();
        check({31'h0, dev.sec_r}, 32'h0);
        check({31'h0, dev.prot_r[3]}, 32'h1);
        // Unprotect all, keeping two boot units and the top unit
        wr(flash_prot_pkg::REG_KEEP, 32'h10003);
        wr(flash_prot_pkg::REG_CMD, 32'h0002);
        wait_idle();
        check({15'h0, dev.prot_r}, 32'h10003);
        check({31'h0, dev.rule_break}, 32'h0);
        check({31'h0, dev.sec_lock_r}, 32'h0);
        rd(flash_prot_pkg::REG_MAP);
        check(rv, 32'h10003);
        ctl(2'h3, 17'h0);
        ctl(2'h2, 17'h3);
        ctl(2'h1, 17'h10003);
        ctl(2'h0, 17'h10003);
        tally_and_finish();
    end
endmodule : testbench
